/* File: inc/ckpm_pkg.sv */
// Summary of operation
// RL1: Low-speed oscillator never becomes processor clock.
// RL2: Low-speed clock feeds the watchdog only.
// RL3: Low-speed oscillator runs exactly while watchdog runs.
// RL4: Watchdog stops by option bit or standby.
// RL5: Only first byte write sticks; bit/byte reads.
// RL6: Reset clears mode register, pins input ports.
// RL7: Two high-speed bits pick port/resonator/external clock.
// RL8: Subsystem bit connects crystal or leaves ports.
// RL9: Drive field: low, normal, super-low, undefined.
// RL10: Range bit picks 2-10 or 10-20 MHz.
// RL11: Software sets range bit above 10 MHz.
// RL12: Software programs mode before starting oscillators.
// RL13: Software writes zero default to consume write.
// RL14: Stabilization count starts on resonator stop release.
// RL15: Unused mode bits read zero, ignore writes.
package ckpm_pkg;

	// Register map and layout
	localparam logic [19:0] CKPM_CFG_ADDR = 20'hfffa0;
	localparam logic [7:0] CKPM_CFG_RESET = 8'h00;
	localparam logic [7:0] CKPM_CFG_USED = 8'hfc;
	localparam int CKPM_EXT_CLK_BIT = 7;
	localparam int CKPM_HS_OSC_BIT = 6;
	localparam int CKPM_SUB_OSC_BIT = 5;
	localparam int CKPM_SUB_DRV_HI_BIT = 4;
	localparam int CKPM_SUB_DRV_LO_BIT = 3;
	localparam int CKPM_HS_RANGE_BIT = 2;
	localparam int CKPM_DATA_W = 8;
	localparam int CKPM_ADDR_W = 20;

	// Reset level of the high-speed stop bit in the run/stop control register
	localparam logic CKPM_HS_STOP_RESET = 1'b1;

	// High-speed pin operating modes
	typedef enum logic [1:0] {
		CKPM_HS_PORT = 2'h0,
		CKPM_HS_RESONATOR = 2'h1,
		CKPM_HS_EXT_CLOCK = 2'h2
	} ckpm_hs_mode_type;

	// Subsystem oscillator drive levels
	typedef enum logic [1:0] {
		CKPM_DRV_LOW = 2'h0,
		CKPM_DRV_NORMAL = 2'h1,
		CKPM_DRV_SUPER_LOW = 2'h2,
		CKPM_DRV_UNDEF = 2'h3
	} ckpm_drive_type;

	// Processor clock sources
	typedef enum logic [1:0] {
		CKPM_SRC_HS_INTERNAL = 2'h0,
		CKPM_SRC_HS_SYSTEM = 2'h1,
		CKPM_SRC_SUBSYSTEM = 2'h2,
		CKPM_SRC_LS_INTERNAL = 2'h3
	} ckpm_clk_src_type;

	// Write-once lifecycle of the mode register
	typedef enum logic [1:0] {
		CKPM_CFG_OPEN = 2'h1,
		CKPM_CFG_LOCKED = 2'h2
	} ckpm_cfg_state_type;

	// Decode of the two high-speed pin bits
	function automatic ckpm_hs_mode_type ckpm_hs_mode(input logic [7:0] cfg);
		if (!cfg[CKPM_HS_OSC_BIT]) begin
			return CKPM_HS_PORT;
		end else if (cfg[CKPM_EXT_CLK_BIT]) begin
			return CKPM_HS_EXT_CLOCK;
		end else begin
			return CKPM_HS_RESONATOR;
		end
	endfunction

endpackage

/* File: inc/ckpm_mode_if.sv */
`timescale 1ns/10ps
// Carries the stored mode byte to the decoder and the decoded modes back
interface ckpm_mode_if;
	logic [7:0] cfg;
	ckpm_pkg::ckpm_hs_mode_type hsMode;
	logic subXtalConn;
	ckpm_pkg::ckpm_drive_type subDrive;
	logic hsRangeHigh;

	modport decoder (
		input cfg,
		output hsMode,
		output subXtalConn,
		output subDrive,
		output hsRangeHigh
	);

	modport owner (
		output cfg,
		input hsMode,
		input subXtalConn,
		input subDrive,
		input hsRangeHigh
	);
endinterface

/* File: rtl/ckpm_mode_decode.sv */
`timescale 1ns/10ps
module ckpm_mode_decode (
	// Mode byte in, decoded modes out
	ckpm_mode_if.decoder modeBus
);
	import ckpm_pkg::*;

	// Pure decode; the owner registers every result before it leaves the block
	assign modeBus.hsMode = ckpm_hs_mode(modeBus.cfg); // RL7
	assign modeBus.subXtalConn = modeBus.cfg[CKPM_SUB_OSC_BIT]; // RL8
	assign modeBus.subDrive = ckpm_drive_type'({modeBus.cfg[CKPM_SUB_DRV_HI_BIT],
		modeBus.cfg[CKPM_SUB_DRV_LO_BIT]}); // RL9
	assign modeBus.hsRangeHigh = modeBus.cfg[CKPM_HS_RANGE_BIT]; // RL10
endmodule

/* File: rtl/ckpm_lsosc_gate.sv */
`timescale 1ns/10ps
module ckpm_lsosc_gate (
	// Option byte bits
	input wire logic watchdogEnableOption,
	input wire logic watchdogStandbyRun,
	// Processor standby status
	input wire logic haltExec,
	input wire logic stopExec,
	// Results
	output logic wdtStopped,
	output logic lsOscRun
);
	// Standby only stops the watchdog when it is not told to keep running
	wire standbyNow = haltExec | stopExec;
	assign wdtStopped = !watchdogEnableOption | (standbyNow & !watchdogStandbyRun); // RL4
	// Oscillator follows the watchdog so no power is spent on an idle clock
	assign lsOscRun = !wdtStopped; // RL3
endmodule

/* File: rtl/ckpm_clock_pin_ctrl.sv */
`timescale 1ns/10ps
module ckpm_clock_pin_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Processor memory access
	input wire logic [ckpm_pkg::CKPM_ADDR_W-1:0] cpuAddr,
	input wire logic cpuWrite,
	input wire logic cpuRead,
	input wire logic cpuBitAccess,
	input wire logic [2:0] cpuBitSel,
	input wire logic [ckpm_pkg::CKPM_DATA_W-1:0] cpuWrData,
	output logic [ckpm_pkg::CKPM_DATA_W-1:0] cpuRdData,
	output logic cpuRdValid,
	// Option byte and standby status
	input wire logic watchdogEnableOption,
	input wire logic watchdogStandbyRun,
	input wire logic haltExec,
	input wire logic stopExec,
	// High-speed stop bit of the run/stop control register
	input wire logic hsClockStop,
	// Processor clock source request
	input wire ckpm_pkg::ckpm_clk_src_type cpuClkSrcReq,
	// High-speed pin control
	output logic hsResonatorPinConn,
	output logic extClockInputEn,
	output ckpm_pkg::ckpm_hs_mode_type hsPinMode,
	output logic hsFreqRange,
	// Subsystem pin control
	output logic subResonatorPinConn,
	output ckpm_pkg::ckpm_drive_type subDriveLevel,
	// Low-speed oscillator and watchdog clock
	output logic lsOscRun,
	output logic wdtClockEn,
	output logic wdtStopped,
	// Processor clock source in use
	output ckpm_pkg::ckpm_clk_src_type cpuClkSrc,
	// Stabilization counter start and lock status
	output logic stabCountStart,
	output logic cfgLocked
);
	import ckpm_pkg::*;

	// Stored mode byte and its lifecycle
	logic [7:0] cfg_q;
	logic [7:0] cfg_d;
	ckpm_cfg_state_type state_q;
	ckpm_cfg_state_type state_d;
	logic locked_q;

	// Read return path
	logic [7:0] rdData_q;
	logic [7:0] rdData_d;
	logic rdValid_q;

	// Registered pin controls
	logic hsResConn_q;
	logic extClkEn_q;
	ckpm_hs_mode_type hsMode_q;
	logic hsRange_q;
	logic subConn_q;
	ckpm_drive_type subDrive_q;

	// Watchdog clock side
	logic lsRun_q;
	logic wdtClkEn_q;
	logic wdtStop_q;

	// Processor clock selection
	ckpm_clk_src_type clkSrc_q;
	ckpm_clk_src_type clkSrc_d;

	// Stabilization start detection
	logic hsStopPrev_q;
	logic stabStart_q;
	logic stabStart_d;

	// Address match and access kinds
	wire addrHit = (cpuAddr == CKPM_CFG_ADDR);
	wire byteWrite = cpuWrite & addrHit & !cpuBitAccess;
	wire readHit = cpuRead & addrHit;
	wire isOpen = (state_q == CKPM_CFG_OPEN);

	// Only a byte write into an unlocked register is taken; bit writes
	// neither change the byte nor use up the single write
	wire takeWrite = byteWrite & isOpen; // RL5

	// Per-bit write with unused positions forced to zero
	logic [7:0] maskedWrData;
	genvar gi;
	generate
		for (gi = 0; gi < CKPM_DATA_W; gi++) begin : gBit
			assign maskedWrData[gi] = CKPM_CFG_USED[gi] & cpuWrData[gi]; // RL15
		end
	endgenerate

	// Next value of the stored byte
	assign cfg_d = takeWrite ? maskedWrData : cfg_q; // RL5

	// Lifecycle: the first accepted write locks the register until reset
	always_comb begin
		case (state_q)
			CKPM_CFG_OPEN: begin
				state_d = takeWrite ? CKPM_CFG_LOCKED : CKPM_CFG_OPEN; // RL5
			end
			CKPM_CFG_LOCKED: begin
				state_d = CKPM_CFG_LOCKED;
			end
			default: begin
				state_d = CKPM_CFG_LOCKED;
			end
		endcase
	end

	// Read data: whole byte, or the chosen bit placed in bit 0
	wire [7:0] cfgVisible = cfg_q & CKPM_CFG_USED; // RL15
	wire [7:0] bitRead = {7'h00, cfgVisible[cpuBitSel]};
	assign rdData_d = cpuBitAccess ? bitRead : cfgVisible; // RL5

	// Mode decoding through the shared carrier
	ckpm_mode_if modeBus ();
	assign modeBus.cfg = cfg_q;

	ckpm_mode_decode uDecode (
		.modeBus(modeBus.decoder)
	);

	// Watchdog stop and oscillator gating
	logic wdtStopNow;
	logic lsRunNow;

	ckpm_lsosc_gate uLsGate (
		.watchdogEnableOption(watchdogEnableOption),
		.watchdogStandbyRun(watchdogStandbyRun),
		.haltExec(haltExec),
		.stopExec(stopExec),
		.wdtStopped(wdtStopNow),
		.lsOscRun(lsRunNow)
	);

	// Pin connections follow the decoded mode; the resonator pin is
	// connected only in resonator mode, the clock input only in external mode
	wire hsResConnNow = (modeBus.hsMode == CKPM_HS_RESONATOR); // RL7
	wire extClkNow = (modeBus.hsMode == CKPM_HS_EXT_CLOCK); // RL7

	// A request for the low-speed clock is refused and the current source
	// kept, since that clock is reserved for the watchdog
	assign clkSrc_d = (cpuClkSrcReq == CKPM_SRC_LS_INTERNAL) ? clkSrc_q
		: cpuClkSrcReq; // RL1

	// Counting starts when the stop bit falls while in resonator mode;
	// uses the function directly so the start sees the stored byte
	wire resonatorMode = (ckpm_hs_mode(cfg_q) == CKPM_HS_RESONATOR);
	assign stabStart_d = resonatorMode & hsStopPrev_q & !hsClockStop; // RL14

	// Mode byte; holds whatever the single accepted write left in it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_q <= CKPM_CFG_RESET; // RL6
		end else begin
			cfg_q <= cfg_d; // RL5
		end
	end

	// Lifecycle; only a reset reopens the register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= CKPM_CFG_OPEN; // RL6
		end else begin
			state_q <= state_d;
		end
	end

	// Lock flag in its own flop, so the port carries no decode logic
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			locked_q <= 1'b0;
		end else begin
			locked_q <= (state_d == CKPM_CFG_LOCKED); // RL5
		end
	end

	// Read data, loaded only by a taken read so it holds between reads
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdData_q <= 8'h00;
		end else begin
			rdData_q <= readHit ? rdData_d : rdData_q; // RL5
		end
	end

	// Read valid, high one edge after each cycle the read request is held
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdValid_q <= 1'b0;
		end else begin
			rdValid_q <= readHit; // RL5
		end
	end

	// High-speed pin connections; both open after reset, pins stay ports
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hsResConn_q <= 1'b0; // RL6
			extClkEn_q <= 1'b0; // RL6
		end else begin
			hsResConn_q <= hsResConnNow; // RL7
			extClkEn_q <= extClkNow; // RL7
		end
	end

	// High-speed mode and frequency range as seen by the oscillator
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hsMode_q <= CKPM_HS_PORT; // RL6
			hsRange_q <= 1'b0;
		end else begin
			hsMode_q <= modeBus.hsMode; // RL7
			hsRange_q <= modeBus.hsRangeHigh; // RL10
		end
	end

	// Subsystem pin connection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			subConn_q <= 1'b0; // RL6
		end else begin
			subConn_q <= modeBus.subXtalConn; // RL8
		end
	end

	// Subsystem drive level; the undefined code is passed on, not remapped
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			subDrive_q <= CKPM_DRV_LOW;
		end else begin
			subDrive_q <= modeBus.subDrive; // RL9
		end
	end

	// Watchdog clock: the low-speed clock is gated only toward the watchdog
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lsRun_q <= 1'b0;
			wdtClkEn_q <= 1'b0;
		end else begin
			lsRun_q <= lsRunNow; // RL3
			wdtClkEn_q <= lsRunNow; // RL2
		end
	end

	// Watchdog stop status; reads stopped while reset holds the oscillator off
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wdtStop_q <= 1'b1;
		end else begin
			wdtStop_q <= wdtStopNow; // RL4
		end
	end

	// Processor clock source; never the low-speed clock
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clkSrc_q <= CKPM_SRC_HS_INTERNAL;
		end else begin
			clkSrc_q <= clkSrc_d; // RL1
		end
	end

	// Stop bit history; resets to the stop bit's own reset level so
	// leaving reset never looks like a release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hsStopPrev_q <= CKPM_HS_STOP_RESET;
		end else begin
			hsStopPrev_q <= hsClockStop; // RL14
		end
	end

	// Start pulse toward the stabilization counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stabStart_q <= 1'b0;
		end else begin
			stabStart_q <= stabStart_d; // RL14
		end
	end

	// Outputs straight from flip-flops: read port
	assign cpuRdData = rdData_q;
	assign cpuRdValid = rdValid_q;

	// Pin controls
	assign hsResonatorPinConn = hsResConn_q;
	assign extClockInputEn = extClkEn_q;
	assign hsPinMode = hsMode_q;
	assign hsFreqRange = hsRange_q;
	assign subResonatorPinConn = subConn_q;
	assign subDriveLevel = subDrive_q;

	// Watchdog side and processor clock
	assign lsOscRun = lsRun_q;
	assign wdtClockEn = wdtClkEn_q;
	assign wdtStopped = wdtStop_q;
	assign cpuClkSrc = clkSrc_q;

	// Status
	assign stabCountStart = stabStart_q;
	assign cfgLocked = locked_q;
endmodule

/* File: verification/ckpm_clock_pin_ctrl_asserts.sv */
`timescale 1ns/10ps
module ckpm_clock_pin_ctrl_asserts (
	// Clock, reset and access
	input wire logic clk,
	input wire logic resetn,
	input wire logic [19:0] cpuAddr,
	input wire logic cpuWrite,
	input wire logic cpuRead,
	input wire logic cpuBitAccess,
	input wire logic [7:0] cpuWrData,
	input wire logic [7:0] cpuRdData,
	input wire logic cpuRdValid,
	input wire logic hsClockStop,
	// Outputs watched
	input wire ckpm_pkg::ckpm_hs_mode_type hsPinMode,
	input wire logic hsResonatorPinConn,
	input wire logic hsFreqRange,
	input wire logic lsOscRun,
	input wire logic wdtClockEn,
	input wire logic wdtStopped,
	input wire ckpm_pkg::ckpm_clk_src_type cpuClkSrc,
	input wire logic stabCountStart,
	input wire logic cfgLocked
);
	import ckpm_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Named causes, since $past takes plain signals
	wire logic rdHit = cpuRead && cpuAddr == CKPM_CFG_ADDR;
	wire logic wrHit = cpuWrite && !cpuBitAccess && cpuAddr == CKPM_CFG_ADDR;
	wire logic wrRange = cpuWrData[CKPM_HS_RANGE_BIT];
	chk_no_ls_cpu: assert property (
		cpuClkSrc != CKPM_SRC_LS_INTERNAL) else $error("cpu on slow clock");
	chk_ls_wdt_only: assert property (
		wdtClockEn |-> lsOscRun) else $error("watchdog clock without osc");
	chk_ls_runs_wdt: assert property (
		lsOscRun == !wdtStopped) else $error("osc and watchdog disagree");
	chk_first_write: assert property (
		wrHit && !cfgLocked |=> cfgLocked ##1 hsFreqRange == $past(wrRange, 2))
		else $error("first write lost");
	chk_locked_hold: assert property (
		cfgLocked && $past(cfgLocked) |=> cfgLocked && $stable(hsPinMode))
		else $error("locked mode changed");
	chk_read_answer: assert property (
		$past(resetn) |-> cpuRdValid == $past(rdHit)) else $error("read valid wrong");
	chk_bit_read: assert property (
		cpuRdValid && $past(cpuBitAccess) |-> cpuRdData[7:1] == 7'h00)
		else $error("bit read upper bits");
	chk_unused_zero: assert property (
		cpuRdValid && !$past(cpuBitAccess) |-> cpuRdData[1:0] == 2'h0)
		else $error("unused bits set");
	chk_hs_decode: assert property (
		hsResonatorPinConn == (hsPinMode == CKPM_HS_RESONATOR)) else $error("hs decode");
	chk_stab_start: assert property (
		stabCountStart |-> hsResonatorPinConn && $past(hsClockStop, 2) && !$past(hsClockStop))
		else $error("stray stabilization start");
	// Main scenarios reached
	cov_lock: cover property ($rose(cfgLocked));
	cov_stab: cover property (stabCountStart);
	cov_bit_read: cover property (cpuRdValid && $past(cpuBitAccess));
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	import ckpm_pkg::*;
	typedef struct packed {
		logic [7:0] d;
		logic [1:0] hm;
		logic sx;
		logic [1:0] dr;
		logic rg;
	} ckpm_row_type;
	// Mode byte, then pin mode, crystal, drive and range it selects
	ckpm_row_type rows [9] = '{'{8'h00, 2'h0, 1'b0, 2'h0, 1'b0},
		'{8'h40, 2'h1, 1'b0, 2'h0, 1'b0}, '{8'hc0, 2'h2, 1'b0, 2'h0, 1'b0},
		'{8'h80, 2'h0, 1'b0, 2'h0, 1'b0}, '{8'h28, 2'h0, 1'b1, 2'h1, 1'b0},
		'{8'h30, 2'h0, 1'b1, 2'h2, 1'b0}, '{8'h18, 2'h0, 1'b0, 2'h3, 1'b0},
		'{8'h04, 2'h0, 1'b0, 2'h0, 1'b1}, '{8'hff, 2'h2, 1'b1, 2'h3, 1'b1}};
	logic [1:0] seq [6] = '{2'h2, 2'h3, 2'h1, 2'h3, 2'h0, 2'h3};
	logic clk = 1'b0, resetn = 1'b0, cpuWrite = 1'b0, cpuRead = 1'b0, cpuBitAccess = 1'b0;
	logic [19:0] cpuAddr = 20'h00000;
	logic [2:0] cpuBitSel = 3'h0;
	logic [7:0] cpuWrData = 8'h00, cpuRdData;
	logic watchdogEnableOption = 1'b1, watchdogStandbyRun = 1'b0, haltExec = 1'b0;
	logic stopExec = 1'b0, hsClockStop = 1'b1, stp, cpuRdValid, hsResonatorPinConn;
	logic extClockInputEn, hsFreqRange, subResonatorPinConn, lsOscRun, wdtClockEn;
	logic wdtStopped, stabCountStart, cfgLocked;
	ckpm_hs_mode_type hsPinMode;
	ckpm_drive_type subDriveLevel;
	ckpm_clk_src_type cpuClkSrc;
	logic [1:0] want;
	ckpm_clk_src_type cpuClkSrcReq = CKPM_SRC_HS_INTERNAL;
	int errCount = 0, checks = 0, cyc = 0;
	logic [15:0] n;
	wire logic [7:0] pins = {hsPinMode, hsResonatorPinConn, extClockInputEn,
		subResonatorPinConn, subDriveLevel, hsFreqRange};
	ckpm_clock_pin_ctrl i_ckpm_clock_pin_ctrl (.clk, .resetn, .cpuAddr, .cpuWrite, .cpuRead,
		.cpuBitAccess, .cpuBitSel, .cpuWrData, .cpuRdData, .cpuRdValid, .watchdogEnableOption,
		.watchdogStandbyRun, .haltExec, .stopExec, .hsClockStop, .cpuClkSrcReq,
		.hsResonatorPinConn, .extClockInputEn, .hsPinMode, .hsFreqRange, .subResonatorPinConn,
		.subDriveLevel, .lsOscRun, .wdtClockEn, .wdtStopped, .cpuClkSrc, .stabCountStart,
		.cfgLocked);
	always #20 clk = ~clk;
	task wrapUp;
		$display("errors %0d checks %0d", errCount, checks);
		if (errCount == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// A hang costs one mismatch and ends the run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			errCount++;
			wrapUp;
		end
	end
	task chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			errCount++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One access, held for a single taking edge
	task acc(input logic w, input logic r, input logic b, input logic [19:0] a,
		input logic [7:0] d);
		@(posedge clk);
		{cpuWrite, cpuRead, cpuBitAccess, cpuAddr, cpuWrData, cpuBitSel} <= {w, r, b, a, d, d[2:0]};
		@(posedge clk);
		{cpuWrite, cpuRead} <= 2'b00;
		#1;
	endtask
	task rst;
		@(posedge clk) resetn <= 1'b0;
		@(posedge clk);
		#1;
		chk({pins, wdtStopped, cfgLocked, cpuRdValid, lsOscRun, cpuClkSrc, wdtClockEn,
			stabCountStart}, 16'h0080);
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
	endtask
	initial begin
		// Each mode byte after a fresh reset, decoded and read back
		foreach (rows[i]) begin
			rst;
			acc(1'b1, 1'b0, 1'b0, CKPM_CFG_ADDR, rows[i].d);
			repeat (2) @(posedge clk);
			#1;
			chk(pins, {rows[i].hm, rows[i].hm == 2'h1, rows[i].hm == 2'h2, rows[i].sx, rows[i].dr,
				rows[i].rg});
			acc(1'b0, 1'b1, 1'b0, CKPM_CFG_ADDR, 8'h00);
			chk(cpuRdData, rows[i].d & CKPM_CFG_USED);
		end
		// Bit writes and foreign addresses must not lock, later writes must not stick
		rst;
		acc(1'b1, 1'b0, 1'b1, CKPM_CFG_ADDR, 8'h40);
		acc(1'b1, 1'b0, 1'b0, CKPM_CFG_ADDR + 20'h1, 8'hc0);
		@(posedge clk);
		#1;
		chk({cfgLocked, pins}, 16'h0000);
		acc(1'b1, 1'b0, 1'b0, CKPM_CFG_ADDR, 8'h44);
		acc(1'b1, 1'b0, 1'b0, CKPM_CFG_ADDR, 8'hff);
		acc(1'b0, 1'b1, 1'b0, CKPM_CFG_ADDR + 20'h1, 8'h00);
		chk(cpuRdValid, 1'b0);
		for (int i = 0; i < 8; i++) begin
			acc(1'b0, 1'b1, 1'b1, CKPM_CFG_ADDR, i[7:0]);
			chk({cpuRdValid, cpuRdData}, {1'b1, 8'h44 >> i & 8'h01});
		end
		// Every option and standby combination
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			{watchdogEnableOption, watchdogStandbyRun, haltExec, stopExec} <= i[3:0];
			@(posedge clk);
			#1;
			stp = !i[3] || !i[2] && (i[1] || i[0]);
			chk({wdtStopped, lsOscRun, wdtClockEn}, {stp, !stp, !stp});
		end
		// Slow clock requests are refused, the source stays
		want = 2'h0;
		foreach (seq[k]) begin
			@(posedge clk);
			cpuClkSrcReq <= ckpm_clk_src_type'(seq[k]);
			@(posedge clk);
			#1;
			if (seq[k] != 2'h3)
				want = seq[k];
			chk(cpuClkSrc, want);
		end
		// Stop release starts counting only in resonator mode
		for (int m = 0; m < 2; m++) begin
			rst;
			// Mode byte goes in before the stop bit releases the resonator
			if (m == 1)
				acc(1'b1, 1'b0, 1'b0, CKPM_CFG_ADDR, 8'h44);
			@(posedge clk);
			hsClockStop <= 1'b0;
			n = 16'h0000;
			repeat (4) begin
				@(posedge clk);
				#1;
				n += stabCountStart;
			end
			chk(n, m[15:0]);
			@(posedge clk);
			hsClockStop <= 1'b1;
		end
		wrapUp;
	end
endmodule
bind ckpm_clock_pin_ctrl ckpm_clock_pin_ctrl_asserts i_ckpm_clock_pin_ctrl_asserts (.clk, .resetn,
	.cpuAddr, .cpuWrite, .cpuRead, .cpuBitAccess, .cpuWrData, .cpuRdData, .cpuRdValid,
	.hsClockStop, .hsPinMode, .hsResonatorPinConn, .hsFreqRange, .lsOscRun, .wdtClockEn,
	.wdtStopped, .cpuClkSrc, .stabCountStart, .cfgLocked);
